// ===== elmc_top.sv
// Module: egress limit and miscellaneous control register bank with APB slave
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
// ------------------------------------------------------------
// ------------------------------------------------------------
module elmc_top
   import elmc_pkg::*;
#(
   parameter bit HAS_CLK_INVERT = 1'b1,
   parameter int CREDIT_W = 30
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic frame_req,
   input wire logic [15:0] frame_len,
   input wire logic [3:0] queue_req,
   output logic frame_grant,
   output logic [3:0] grant_queue,
   output logic port3_fiber,
   output logic rx_clock_invert,
   input wire logic port5_rmii_clk_in,
   output logic switch_rx_clock_out
);
   // Below 29 bits a 2000 byte frame overflows the credit counter
   if (CREDIT_W < 29 || CREDIT_W > 32) begin : g_credit_check
      $error("CREDIT_W out of range");
   end

   elmc_shaper_if sif ();

   logic [6:0] limit_reg;
   logic [1:0] qmode_reg;
   logic [7:0] ratio_reg [4];
   logic port3_fiber_reg;
   logic rx_inv_reg;
   logic [31:0] rdata_next;
   logic err_next;
   logic wr_access;
   logic acc_phase;
   logic [9:0] off;
   logic clk_sync1_reg;
   logic clk_sync2_reg;
   logic [7:0] grant_count_reg;

   function automatic logic is_ratio(input logic [9:0] a);
      return a >= ELMC_OFF_RATIO_BASE && a < ELMC_OFF_RATIO_BASE + 10'h010
         && a[1:0] == 2'b00;
   endfunction

   function automatic logic [1:0] ratio_idx(input logic [9:0] a);
      logic [9:0] d;
      d = a - ELMC_OFF_RATIO_BASE;
      return d[3:2];
   endfunction

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   // Printed offsets are not word aligned, so the index maps to index*4 byte address
   assign off = paddr[ELMC_ADDR_W+1:2];
   assign acc_phase = psel && penable && !pready;
   assign wr_access = acc_phase && pwrite;

   always_comb begin
      rdata_next = 32'h0000_0000;
      err_next = 1'b0;
      case (off)
         ELMC_OFF_TEST1: rdata_next = {24'h000000, ELMC_RST_TEST1};
         ELMC_OFF_RSVD_CTL: rdata_next = {24'h000000, ELMC_RST_RSVD_CTL};
         ELMC_OFF_TEST2: rdata_next = {24'h000000, ELMC_RST_TEST2};
         ELMC_OFF_P3_MEDIUM: rdata_next = {31'h0, port3_fiber_reg};
         ELMC_OFF_TEST3: rdata_next = {24'h000000, ELMC_RST_TEST3};
         ELMC_OFF_Q3_LIMIT: rdata_next = {25'h0, limit_reg};
         ELMC_OFF_RMII_PHASE: rdata_next = {27'h0, rx_inv_reg, 4'h0};
         ELMC_OFF_QUEUE_MODE: rdata_next = {30'h0, qmode_reg};
         ELMC_OFF_SHAPER_STAT: rdata_next = {23'h0, sif.limited, grant_count_reg};
         default: begin
            if (is_ratio(off)) begin
               rdata_next = {24'h000000, ratio_reg[ratio_idx(off)]};
            end else begin
               err_next = 1'b1;
            end
         end
      endcase
   end

   // One wait state: answer one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= acc_phase;
         pslverr <= acc_phase && err_next;
         if (acc_phase && !pwrite) begin
            prdata <= rdata_next;
         end
      end
   end

   // ------------------------------------------------------------
   // Writable registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port3_fiber_reg <= ELMC_RST_P3_MEDIUM[ELMC_BIT_P3_FIBER];
      end else if (wr_access && off == ELMC_OFF_P3_MEDIUM && pstrb[0]) begin
         port3_fiber_reg <= pwdata[ELMC_BIT_P3_FIBER];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_inv_reg <= ELMC_RST_RMII_PHASE[ELMC_BIT_RMII_INV];
      end else if (wr_access && off == ELMC_OFF_RMII_PHASE && pstrb[0] && HAS_CLK_INVERT) begin
         rx_inv_reg <= pwdata[ELMC_BIT_RMII_INV];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         limit_reg <= ELMC_RST_LIMIT;
      end else if (wr_access && off == ELMC_OFF_Q3_LIMIT && pstrb[0]) begin
         limit_reg <= pwdata[6:0];
      end
   end

   // Software must set this before per-priority egress limiting is relied on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qmode_reg <= ELMC_RST_QUEUE_MODE;
      end else if (wr_access && off == ELMC_OFF_QUEUE_MODE && pstrb[0]) begin
         qmode_reg <= pwdata[1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < ELMC_NUM_RATIO; i++) begin
            ratio_reg[i] <= ELMC_RST_RATIO;
         end
      end else if (wr_access && is_ratio(off) && pstrb[0]) begin
         ratio_reg[ratio_idx(off)] <= pwdata[7:0];
      end
   end

   // ------------------------------------------------------------
   // Shaper
   // ------------------------------------------------------------
   assign sif.limit = limit_reg;
   assign sif.queue_mode = qmode_reg;
   assign sif.frame_req = frame_req;
   assign sif.frame_len = frame_len;
   assign sif.queue_req = queue_req;
   always_comb begin
      for (int i = 0; i < ELMC_NUM_RATIO; i++) begin
         sif.ratio[i] = ratio_reg[i];
      end
   end

   elmc_shaper #(
      .CREDIT_W(CREDIT_W)
   ) u_shaper (
      .pclk(pclk),
      .presetn(presetn),
      .sif(sif)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_grant <= 1'b0;
         grant_queue <= 4'h0;
         grant_count_reg <= 8'h00;
      end else begin
         frame_grant <= sif.frame_grant;
         grant_queue <= sif.grant_queue;
         if (sif.frame_grant) begin
            grant_count_reg <= grant_count_reg + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // Port controls and receive clock phase
   // ------------------------------------------------------------
   // Clock is sampled, so output edge resolution is one pclk period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_sync1_reg <= 1'b0;
         clk_sync2_reg <= 1'b0;
      end else begin
         clk_sync1_reg <= port5_rmii_clk_in;
         clk_sync2_reg <= clk_sync1_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port3_fiber <= 1'b0;
         rx_clock_invert <= 1'b0;
         switch_rx_clock_out <= 1'b0;
      end else begin
         port3_fiber <= port3_fiber_reg;
         rx_clock_invert <= rx_inv_reg;
         switch_rx_clock_out <= clk_sync2_reg ^ rx_inv_reg;
      end
   end
endmodule

// ===== elmc_pkg.sv
// Package: register map, reset values and rate encodings for the egress limit block
package elmc_pkg;
   localparam int ELMC_ADDR_W = 10;
   localparam logic [9:0] ELMC_OFF_TEST1 = 10'h0BF;
   localparam logic [9:0] ELMC_OFF_RSVD_CTL = 10'h0CF;
   localparam logic [9:0] ELMC_OFF_TEST2 = 10'h0DF;
   localparam logic [9:0] ELMC_OFF_P3_MEDIUM = 10'h0EF;
   localparam logic [9:0] ELMC_OFF_TEST3 = 10'h0FF;
   localparam logic [9:0] ELMC_OFF_Q3_LIMIT = 10'h100;
   localparam logic [9:0] ELMC_OFF_RMII_PHASE = 10'h104;
   localparam logic [9:0] ELMC_OFF_QUEUE_MODE = 10'h108;
   localparam logic [9:0] ELMC_OFF_RATIO_BASE = 10'h10C;
   localparam logic [9:0] ELMC_OFF_SHAPER_STAT = 10'h11C;
   localparam logic [7:0] ELMC_RST_TEST1 = 8'h80;
   localparam logic [7:0] ELMC_RST_RSVD_CTL = 8'h15;
   localparam logic [7:0] ELMC_RST_TEST2 = 8'h0C;
   localparam logic [7:0] ELMC_RST_TEST3 = 8'h32;
   localparam logic [7:0] ELMC_RST_P3_MEDIUM = 8'h00;
   localparam logic [7:0] ELMC_RST_RMII_PHASE = 8'h00;
   localparam logic [6:0] ELMC_RST_LIMIT = 7'h00;
   localparam logic [1:0] ELMC_RST_QUEUE_MODE = 2'h0;
   localparam logic [7:0] ELMC_RST_RATIO = 8'h01;
   localparam int ELMC_BIT_P3_FIBER = 0;
   localparam int ELMC_BIT_RMII_INV = 4;
   localparam logic [6:0] ELMC_LIM_MBPS_MAX = 7'h63;
   localparam logic [6:0] ELMC_LIM_NONE = 7'h64;
   localparam logic [6:0] ELMC_LIM_KBPS_MAX = 7'h73;
   localparam int ELMC_CLK_MHZ = 125;
   localparam int ELMC_KBPS_STEP = 64;
   localparam int ELMC_BYTE_BITS = 8;
   localparam int ELMC_NUM_RATIO = 4;
   typedef enum logic [1:0] {
      ELMC_QM_ONE,
      ELMC_QM_TWO,
      ELMC_QM_FOUR,
      ELMC_QM_RSVD
   } elmc_qmode_type;
endpackage

// ===== elmc_shaper_if.sv
// Interface: limit setting and pacing handshake between register bank and shaper
`timescale 1ns/1ns
interface elmc_shaper_if;
   logic [6:0] limit;
   logic [1:0] queue_mode;
   logic [7:0] ratio [4];
   logic frame_req;
   logic [15:0] frame_len;
   logic frame_grant;
   logic [3:0] grant_queue;
   logic [3:0] queue_req;
   logic limited;
   modport bank (output limit, queue_mode, ratio, frame_req, frame_len, queue_req,
      input frame_grant, grant_queue, limited);
   modport shaper (input limit, queue_mode, ratio, frame_req, frame_len, queue_req,
      output frame_grant, grant_queue, limited);
endinterface

// ===== elmc_shaper.sv
// Module: token bucket shaper and weighted scheduler for one egress port
`timescale 1ns/1ns
module elmc_shaper
   import elmc_pkg::*;
#(
   parameter int CREDIT_W = 30
) (
   input wire logic pclk,
   input wire logic presetn,
   elmc_shaper_if.shaper sif
);
   // Below 29 bits a 2000 byte frame overflows the doubled credit cap
   if (CREDIT_W < 29) begin : g_credit_check
      $error("CREDIT_W too small for a full frame");
   end

   // Credit per clock is the rate in bytes per millisecond
   function automatic logic [CREDIT_W-1:0] rate_inc(input logic [6:0] lim);
      logic [CREDIT_W-1:0] r;
      r = '0;
      if (lim >= 7'h01 && lim <= ELMC_LIM_MBPS_MAX) begin
         r = CREDIT_W'(lim) * CREDIT_W'(1000 / ELMC_BYTE_BITS);
      end else if (lim > ELMC_LIM_NONE && lim <= ELMC_LIM_KBPS_MAX) begin
         r = CREDIT_W'(lim - ELMC_LIM_NONE) * CREDIT_W'(ELMC_KBPS_STEP / ELMC_BYTE_BITS);
      end
      return r;
   endfunction

   logic [CREDIT_W-1:0] credit_reg;
   logic [CREDIT_W-1:0] need;
   logic [CREDIT_W-1:0] cap;
   logic unlimited;
   logic [3:0] eligible;
   logic [7:0] weight_reg [4];
   logic [3:0] grant_next;
   logic all_spent;

   // A frame costs its byte count times the clocks in one millisecond
   assign need = CREDIT_W'(sif.frame_len) * CREDIT_W'(ELMC_CLK_MHZ * 1000);
   assign cap = need << 1;
   assign unlimited = (sif.limit == 7'h00) || (sif.limit == ELMC_LIM_NONE)
      || (sif.limit > ELMC_LIM_KBPS_MAX);

   // ------------------------------------------------------------
   // Token bucket on the top priority queue
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         credit_reg <= '0;
      end else if (unlimited) begin
         // No saving up while unlimited, or a later limit would start with a burst
         credit_reg <= '0;
      end else if (sif.frame_grant && grant_queue_top()) begin
         credit_reg <= (credit_reg > need) ? credit_reg - need : '0;
      end else if (credit_reg < cap) begin
         credit_reg <= credit_reg + rate_inc(sif.limit);
      end
   end

   // With one queue the only queue is the top one
   function automatic logic grant_queue_top();
      if (sif.queue_mode == ELMC_QM_ONE) begin
         return sif.grant_queue[0];
      end
      return sif.grant_queue[3];
   endfunction

   // ------------------------------------------------------------
   // Scheduling: queue 3 first, lower queues by weight
   // ------------------------------------------------------------
   always_comb begin
      eligible = sif.queue_req;
      case (sif.queue_mode)
         ELMC_QM_ONE: eligible = {3'b000, |sif.queue_req};
         ELMC_QM_TWO: eligible = {sif.queue_req[3], 2'b00, |sif.queue_req[2:0]};
         ELMC_QM_FOUR: eligible = sif.queue_req;
         default: eligible = sif.queue_req;
      endcase
      if (sif.queue_mode != ELMC_QM_ONE && !unlimited && credit_reg < need) begin
         eligible[3] = 1'b0;
      end
      if (sif.queue_mode == ELMC_QM_ONE && !unlimited && credit_reg < need) begin
         eligible[0] = 1'b0;
      end
   end

   assign all_spent = (weight_reg[0] == 8'h00) && (weight_reg[1] == 8'h00)
      && (weight_reg[2] == 8'h00);

   always_comb begin
      grant_next = 4'h0;
      if (eligible[3]) begin
         grant_next = 4'h8;
      end else if (eligible[2] && (weight_reg[2] != 8'h00 || all_spent)) begin
         grant_next = 4'h4;
      end else if (eligible[1] && (weight_reg[1] != 8'h00 || all_spent)) begin
         grant_next = 4'h2;
      end else if (eligible[0]) begin
         grant_next = 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sif.grant_queue <= 4'h0;
         sif.frame_grant <= 1'b0;
      end else begin
         sif.grant_queue <= sif.frame_req ? grant_next : 4'h0;
         sif.frame_grant <= sif.frame_req && (grant_next != 4'h0) && !sif.frame_grant;
      end
   end

   // Weights reload once the lower queues have spent their share
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < ELMC_NUM_RATIO; i++) begin
            weight_reg[i] <= ELMC_RST_RATIO;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (all_spent) begin
               weight_reg[i] <= sif.ratio[i];
            end else if (sif.frame_grant && sif.grant_queue[i] && weight_reg[i] != 8'h00) begin
               weight_reg[i] <= weight_reg[i] - 8'h01;
            end
         end
         weight_reg[3] <= sif.ratio[3];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sif.limited <= 1'b0;
      end else begin
         sif.limited <= !unlimited && credit_reg < need;
      end
   end
endmodule

// ===== elmc_assertions.sv
// Checker: bus, register and shaper assertions for elmc_top
`timescale 1ns/1ns
module elmc_assertions
   import elmc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] queue_req,
   input wire logic frame_grant,
   input wire logic [3:0] grant_queue,
   input wire logic port3_fiber,
   input wire logic rx_clock_invert,
   input wire logic port5_rmii_clk_in,
   input wire logic switch_rx_clock_out
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic [9:0] idx;
   logic fib_wr;
   logic inv_wr;
   logic fib_val;
   logic [1:0] up_cnt;
   assign idx = paddr[11:2];
   assign fib_wr = psel && penable && pready && pwrite && idx == ELMC_OFF_P3_MEDIUM;
   assign inv_wr = psel && penable && pready && pwrite && idx == ELMC_OFF_RMII_PHASE;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fib_val <= 1'b0;
      end else if (fib_wr) begin
         fib_val <= pwdata[ELMC_BIT_P3_FIBER];
      end
   end
   // Phase check waits until the synchroniser holds post-reset samples
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_cnt <= 2'h0;
      end else if (up_cnt != 2'h3) begin
         up_cnt <= up_cnt + 2'h1;
      end
   end
   // ------
   // Assertions
   // ------
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready too long");
   a_ready_next: assert property ($rose(penable) && psel |=> pready)
      else $error("pready late");
   a_err_unmapped: assert property (pready && idx > ELMC_OFF_SHAPER_STAT |->
      pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_ro_fixed: assert property (pready && idx == ELMC_OFF_TEST3 |->
      !pslverr && (pwrite || prdata == {24'h0, ELMC_RST_TEST3}))
      else $error("fixed register moved");
   a_fiber_take: assert property (fib_wr |=> ##[0:1] port3_fiber == fib_val)
      else $error("medium not taken");
   a_fiber_hold: assert property (!$stable(port3_fiber) |->
      $past(fib_wr) || $past(fib_wr, 2))
      else $error("medium changed alone");
   a_inv_hold: assert property (!$stable(rx_clock_invert) |->
      $past(inv_wr) || $past(inv_wr, 2))
      else $error("invert changed alone");
   a_clk_phase: assert property (up_cnt == 2'h3 &&
      rx_clock_invert == $past(rx_clock_invert, 3) |->
      switch_rx_clock_out == ($past(port5_rmii_clk_in, 3) ^ rx_clock_invert))
      else $error("clock phase wrong");
   a_grant_pulse: assert property (frame_grant |=> !frame_grant)
      else $error("grant too long");
   a_grant_queue: assert property (frame_grant |-> $onehot(grant_queue) &&
      ((grant_queue & ($past(queue_req) | $past(queue_req, 2))) != 4'h0
      || (grant_queue == 4'h1 && ($past(queue_req) | $past(queue_req, 2)) != 4'h0)))
      else $error("grant to idle queue");
endmodule
bind elmc_top elmc_assertions elmc_assertions_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .queue_req(queue_req),
   .frame_grant(frame_grant), .grant_queue(grant_queue), .port3_fiber(port3_fiber),
   .rx_clock_invert(rx_clock_invert), .port5_rmii_clk_in(port5_rmii_clk_in),
   .switch_rx_clock_out(switch_rx_clock_out));

// ===== elmc_top_tb.sv
// Testbench: register, bus and shaper scenarios for elmc_top
`timescale 1ns/1ns
module elmc_top_tb
   import elmc_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [3:0] pstrb, queue_req, grant_queue;
   logic [15:0] frame_len;
   logic frame_req, frame_grant, fiber, inv, clk_in, sw_out;
   int err_total = 0;
   int samples_checked = 0;
   logic [9:0] ix_tab [9] = '{ELMC_OFF_TEST1, ELMC_OFF_RSVD_CTL, ELMC_OFF_TEST2,
      ELMC_OFF_TEST3, ELMC_OFF_P3_MEDIUM, ELMC_OFF_Q3_LIMIT, ELMC_OFF_RMII_PHASE,
      ELMC_OFF_QUEUE_MODE, ELMC_OFF_RATIO_BASE};
   logic [7:0] rst_tab [9] = '{ELMC_RST_TEST1, ELMC_RST_RSVD_CTL, ELMC_RST_TEST2,
      ELMC_RST_TEST3, ELMC_RST_P3_MEDIUM, 8'h00, ELMC_RST_RMII_PHASE, 8'h00, ELMC_RST_RATIO};
   logic [6:0] lim_tab [5] = '{7'h01, ELMC_LIM_MBPS_MAX, ELMC_LIM_NONE, 7'h65, ELMC_LIM_KBPS_MAX};
   always #4 pclk = ~pclk;
   elmc_top elmc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .frame_req(frame_req), .frame_len(frame_len),
      .queue_req(queue_req), .frame_grant(frame_grant), .grant_queue(grant_queue),
      .port3_fiber(fiber), .rx_clock_invert(inv), .port5_rmii_clk_in(clk_in),
      .switch_rx_clock_out(sw_out));
   // ------
   // Shared tasks
   // ------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input int got, input int lo, input int hi);
      samples_checked++;
      if (got < lo || got > hi) begin
         err_total++;
         $display("[FAIL] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask
   // Holds the request until pready is sampled; the wait is bounded
   task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {20'h0, ix, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      chk_rng(n, 0, 19);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // ------
   // Scenarios
   // ------
   task automatic t_defaults();
      for (int i = 0; i < 9; i++) begin
         apb(1'b0, ix_tab[i], 8'h00);
         chk(rd, {24'h0, rst_tab[i]});
      end
   endtask
   task automatic t_ro();
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, ix_tab[i], 8'hFF);
         apb(1'b0, ix_tab[i], 8'h00);
         chk(rd, {24'h0, rst_tab[i]});
         chk(er, 1'b0);
      end
   endtask
   task automatic t_medium();
      apb(1'b1, ELMC_OFF_P3_MEDIUM, 8'h01);
      repeat (2) @(posedge pclk);
      chk(fiber, 1'b1);
      apb(1'b0, ELMC_OFF_P3_MEDIUM, 8'h00);
      chk(rd, 32'h1);
      apb(1'b1, ELMC_OFF_P3_MEDIUM, 8'h00);
      repeat (2) @(posedge pclk);
      chk(fiber, 1'b0);
   endtask
   task automatic t_invert();
      apb(1'b1, ELMC_OFF_RMII_PHASE, 8'h1F);
      apb(1'b0, ELMC_OFF_RMII_PHASE, 8'h00);
      chk(rd, 32'h10);
      clk_in <= 1'b1;
      repeat (5) @(posedge pclk);
      chk(inv, 1'b1);
      chk(sw_out, 1'b0);
      clk_in <= 1'b0;
      repeat (5) @(posedge pclk);
      chk(sw_out, 1'b1);
      apb(1'b1, ELMC_OFF_RMII_PHASE, 8'h00);
      repeat (5) @(posedge pclk);
      chk(sw_out, 1'b0);
      clk_in <= 1'b1;
      repeat (5) @(posedge pclk);
      chk(inv, 1'b0);
      chk(sw_out, 1'b1);
   endtask
   task automatic t_unmapped();
      apb(1'b1, 10'h3FF, 8'hA5);
      chk(er, 1'b1);
      apb(1'b0, 10'h3FF, 8'h00);
      chk(rd, 32'h0);
      chk(er, 1'b1);
   endtask
   task automatic t_limits();
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, ELMC_OFF_Q3_LIMIT, {1'b0, lim_tab[i]});
         apb(1'b0, ELMC_OFF_Q3_LIMIT, 8'h00);
         chk(rd, {25'h0, lim_tab[i]});
      end
   endtask
   // One-byte frames: about one per 10 cycles at 99 Mbps, one per 1000 at 1 Mbps
   task automatic t_shape(input logic [6:0] lim, input logic [3:0] q, input int cyc,
      input int lo, input int hi, input int q3hi, input logic [3:0] first);
      int tot;
      int q3;
      logic [3:0] fg;
      tot = 0;
      q3 = 0;
      fg = 4'h0;
      apb(1'b1, ELMC_OFF_Q3_LIMIT, {1'b0, lim});
      queue_req <= q;
      frame_req <= 1'b1;
      repeat (cyc) begin
         @(posedge pclk);
         if (frame_grant === 1'b1) begin
            tot++;
            q3 += (grant_queue === 4'h8);
            fg = (fg === 4'h0) ? grant_queue : fg;
            frame_req <= 1'b0;
         end else begin
            frame_req <= 1'b1;
         end
      end
      frame_req <= 1'b0;
      queue_req <= 4'h0;
      repeat (4) @(posedge pclk);
      chk_rng(tot, lo, hi);
      chk_rng(q3, 0, q3hi);
      if (first !== 4'h0) begin
         chk(fg, first);
      end
   endtask
   task automatic wrap_up();
      $display("checked %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      wrap_up();
   end
   initial begin
      {presetn, psel, penable, pwrite, frame_req, clk_in} = 6'h0;
      paddr = 32'h0;
      pwdata = 32'h0;
      pstrb = 4'hF;
      queue_req = 4'h0;
      frame_len = 16'h0001;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_defaults();
      t_ro();
      t_medium();
      t_invert();
      t_unmapped();
      t_limits();
      apb(1'b1, ELMC_OFF_QUEUE_MODE, {6'h0, ELMC_QM_FOUR});
      t_shape(7'h00, 4'h8, 400, 60, 200, 200, 4'h8);
      t_shape(ELMC_LIM_MBPS_MAX, 4'h8, 400, 30, 45, 45, 4'h8);
      t_shape(7'h01, 4'h8, 2100, 1, 3, 3, 4'h8);
      t_shape(7'h65, 4'h8, 400, 0, 1, 1, 4'h0);
      t_shape(ELMC_LIM_NONE, 4'h9, 400, 60, 200, 200, 4'h8);
      t_shape(ELMC_LIM_MBPS_MAX, 4'h9, 400, 150, 200, 45, 4'h1);
      apb(1'b1, ELMC_OFF_QUEUE_MODE, {6'h0, ELMC_QM_ONE});
      t_shape(ELMC_LIM_MBPS_MAX, 4'h8, 400, 30, 47, 0, 4'h1);
      apb(1'b1, ELMC_OFF_QUEUE_MODE, {6'h0, ELMC_QM_TWO});
      t_shape(7'h00, 4'h3, 400, 60, 200, 0, 4'h1);
      wrap_up();
   end
endmodule
